// file: rtl/mawsup_pkg.sv
// Constants and types for the motor alarm and warning supervisor.
// Assumes a single 200 MHz clock and an APB register port.
package mawsup_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned LOCK_TIME_MS    = 1000;
  localparam int unsigned LOCK_CYCLES     = LOCK_TIME_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Speed and history
  // ----------------------------------------------------------------------
  localparam logic [15:0] BRAKE_RPM       = 16'h0834;
  localparam logic [15:0] SPD_HI_RESET    = 16'hFFFF;
  localparam int unsigned HIST_DEPTH      = 9;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_SPEED_LIM    = 8'h04;
  localparam logic [7:0] REG_OPDATA       = 8'h08;
  localparam logic [7:0] REG_STATUS       = 8'h0C;
  localparam logic [7:0] REG_CMD          = 8'h10;
  localparam logic [7:0] REG_HIST_SEL     = 8'h14;
  localparam logic [7:0] REG_HIST_DATA    = 8'h18;
  localparam logic [7:0] REG_WARN         = 8'h1C;

  // CTRL fields
  localparam int unsigned CTRL_EXT_EN     = 0;
  localparam int unsigned CTRL_DIR_INV    = 1;
  localparam int unsigned CTRL_LOCK       = 2;
  localparam int unsigned CTRL_MONITOR    = 3;
  localparam int unsigned CTRL_INCHING    = 4;
  localparam int unsigned CTRL_TH_ASSIGN  = 5;
  localparam int unsigned CTRL_CA_ASSIGN  = 6;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // CMD fields, write one to act; history clear acts only while CTRL_MONITOR is set
  localparam int unsigned CMD_PANEL_CLR   = 0;
  localparam int unsigned CMD_HIST_CLR    = 1;

  // Warning bits
  localparam int unsigned WARN_LOCK       = 0;
  localparam int unsigned WARN_OPERR      = 1;
  localparam logic [7:0]  WARN_CODE_LOCK  = 8'h30;
  localparam logic [7:0]  WARN_CODE_OPERR = 8'h6C;

  // Alarm codes kept in history
  typedef enum logic [7:0]
  {
    MAWS_AL_NONE     = 8'h00,
    MAWS_AL_OVERHEAT = 8'h26
  } mawsup_alarm_t;

  typedef enum logic [1:0]
  {
    MAWS_RUN   = 2'b00,
    MAWS_ALARM = 2'b01,
    MAWS_STOP  = 2'b11
  } mawsup_state_t;

endpackage

// file: rtl/mawsup_top.sv
// Motor alarm and warning supervisor: alarms, history, warnings, run gate.
// Assumes inputs synchronous to ref_clk and an APB master for settings.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module mawsup_top
  import mawsup_pkg::*;
#(
  parameter int unsigned LOCK_LIMIT = LOCK_CYCLES,
  parameter int unsigned DEPTH      = HIST_DEPTH
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Host discrete inputs
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  input  wire logic        coast_input,
  input  wire logic        fault_clear_input,
  input  wire logic        speed_select_bit0,
  input  wire logic        speed_select_bit1,
  // Motor sense
  input  wire logic        thermal_open,
  input  wire logic        shaft_locked,
  input  wire logic [15:0] shaft_rpm,
  input  wire logic [15:0] ext_speed,
  // Operation panel
  input  wire logic        panel_clear,
  input  wire logic        panel_write,
  input  wire logic [15:0] panel_speed,
  // Outputs
  output logic             alarm_output_n,
  output logic             thermal_state_output,
  output logic             caution_output,
  output logic             brake_on,
  output logic             drive_en,
  output logic             drive_forward,
  output logic [15:0]      speed_cmd
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0]       ctrl;
  logic [15:0]       spd_hi;
  logic [15:0]       spd_lo;
  logic [15:0]       op_speed;
  logic [3:0]        hist_sel;
  logic [7:0]        hist [DEPTH];
  logic [3:0]        hist_cnt;
  logic [1:0]        warn;
  logic [1:0]        warn_seen;
  logic [7:0]        warn_last;
  mawsup_state_t     state;
  logic              clr_prev;
  logic              incl_prev;
  logic [31:0]       lock_cnt;

  logic              wr;
  logic              rd;
  logic              clr_edge;
  logic              run_req;
  logic              alarm_new;
  logic              any_clear;
  logic              hist_clear;
  logic              leave_inching;
  logic              run_ok;
  logic [15:0]       raw_speed;
  logic [15:0]       next_speed;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign run_req = forward_run_input || reverse_run_input;

  // ----------------------------------------------------------------------
  // Alarm clear sources
  // ----------------------------------------------------------------------
  // Edge needs the previous level; a level held high clears only once
  assign clr_edge = fault_clear_input && !clr_prev;
  assign any_clear = (clr_edge && !run_req)
                   || panel_clear
                   || (wr && paddr == REG_CMD && pwdata[CMD_PANEL_CLR]);
  assign alarm_new = thermal_open && state != MAWS_ALARM;
  assign hist_clear = wr && paddr == REG_CMD && pwdata[CMD_HIST_CLR]
                    && ctrl[CTRL_MONITOR];
  assign leave_inching = incl_prev && !ctrl[CTRL_INCHING];

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clr_prev  <= 1'b0;
      incl_prev <= 1'b0;
    end
    else
    begin
      clr_prev  <= fault_clear_input;
      incl_prev <= ctrl[CTRL_INCHING];
    end
  end

  // ----------------------------------------------------------------------
  // Alarm state, cleared by reset as a control supply cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= MAWS_RUN;
    else
    begin
      case (state)
        MAWS_RUN:
        begin
          if (thermal_open)
            state <= MAWS_ALARM;
          else if (warn[WARN_OPERR])
            state <= MAWS_STOP;
        end
        MAWS_ALARM:
        begin
          // A still-open protector keeps the alarm despite a clear
          if (any_clear && !thermal_open)
            state <= MAWS_RUN;
        end
        MAWS_STOP:
        begin
          if (thermal_open)
            state <= MAWS_ALARM;
          else if (!warn[WARN_OPERR])
            state <= MAWS_RUN;
        end
        default:
          state <= MAWS_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Alarm history, newest at entry zero
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      hist_cnt <= 4'h0;
    else if (alarm_new)
      hist_cnt <= (hist_cnt == 4'(DEPTH)) ? hist_cnt : hist_cnt + 4'h1;
    else if (hist_clear)
      hist_cnt <= 4'h0;
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_hist
    localparam int unsigned PREV = (i == 0) ? 0 : i - 1;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
      if (!rst_b)
        hist[i] <= MAWS_AL_NONE;
      else if (alarm_new)
        // Shift drops the last entry when full
        hist[i] <= (i == 0) ? MAWS_AL_OVERHEAT : hist[PREV];
      else if (hist_clear)
        hist[i] <= MAWS_AL_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Warnings, volatile; caution follows the live condition
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lock_cnt <= '0;
    else if (!shaft_locked)
      lock_cnt <= '0;
    else if (lock_cnt < LOCK_LIMIT)
      lock_cnt <= lock_cnt + 32'h1;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      warn <= 2'h0;
    else
    begin
      warn[WARN_LOCK] <= shaft_locked && lock_cnt >= LOCK_LIMIT - 1;
      if (leave_inching && run_req)
        warn[WARN_OPERR] <= 1'b1;
      else if (!run_req)
        warn[WARN_OPERR] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      warn_seen <= 2'h0;
      warn_last <= 8'h00;
    end
    else
    begin
      warn_seen <= warn_seen | warn;
      if (warn[WARN_OPERR])
        warn_last <= WARN_CODE_OPERR;
      else if (warn[WARN_LOCK])
        warn_last <= WARN_CODE_LOCK;
    end
  end

  // ----------------------------------------------------------------------
  // Settings, APB and panel
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl     <= CTRL_RESET;
      spd_hi   <= SPD_HI_RESET;
      spd_lo   <= 16'h0000;
      op_speed <= 16'h0000;
      hist_sel <= 4'h0;
    end
    else
    begin
      if (wr && paddr == REG_CTRL)
        ctrl <= pwdata;
      if (wr && paddr == REG_SPEED_LIM)
      begin
        spd_lo <= pwdata[15:0];
        spd_hi <= pwdata[31:16];
      end
      if (wr && paddr == REG_OPDATA)
        op_speed <= pwdata[15:0];
      else if (panel_write && !ctrl[CTRL_LOCK])
        op_speed <= panel_speed;
      if (wr && paddr == REG_HIST_SEL)
        hist_sel <= pwdata[3:0];
    end
  end

  always_comb
  begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (rd)
    begin
      case (paddr)
        REG_CTRL:      prdata = ctrl;
        REG_SPEED_LIM: prdata = {spd_hi, spd_lo};
        REG_OPDATA:    prdata = {16'h0000, op_speed};
        REG_STATUS:    prdata = {26'h0, hist_cnt, state};
        REG_CMD:       prdata = 32'h0000_0000;
        REG_HIST_SEL:  prdata = {28'h0, hist_sel};
        REG_HIST_DATA: prdata = (hist_sel < 4'(DEPTH)) ?
                                {24'h0, hist[hist_sel]} : 32'h0;
        REG_WARN:      prdata = {20'h0, warn_last, warn_seen, warn};
        default:       pslverr = psel && penable;
      endcase
    end
    else if (psel && penable)
      pslverr = !(paddr inside {REG_CTRL, REG_SPEED_LIM, REG_OPDATA,
                  REG_STATUS, REG_CMD, REG_HIST_SEL, REG_HIST_DATA,
                  REG_WARN});
  end

  // ----------------------------------------------------------------------
  // Speed selection and run gate
  // ----------------------------------------------------------------------
  always_comb
  begin
    raw_speed = op_speed;
    if (!speed_select_bit0 && !speed_select_bit1
        && ctrl[CTRL_EXT_EN])
      raw_speed = ext_speed;
    next_speed = raw_speed;
    if (next_speed > spd_hi)
      next_speed = spd_hi;
    if (next_speed < spd_lo)
      next_speed = spd_lo;
  end

  // Lower limit deliberately applied after the empty check is skipped
  assign run_ok = (forward_run_input ^ reverse_run_input)
               && !coast_input
               && (raw_speed != 16'h0000 || spd_lo != 16'h0000)
               && state == MAWS_RUN;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drive_en      <= 1'b0;
      drive_forward <= 1'b1;
      speed_cmd     <= 16'h0000;
      brake_on      <= 1'b0;
    end
    else
    begin
      drive_en      <= run_ok;
      drive_forward <= forward_run_input ^ ctrl[CTRL_DIR_INV];
      speed_cmd     <= run_ok ? next_speed : 16'h0000;
      brake_on      <= shaft_rpm > BRAKE_RPM;
    end
  end

  // ----------------------------------------------------------------------
  // Status pins
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alarm_output_n       <= 1'b1;
      thermal_state_output <= 1'b0;
      caution_output       <= 1'b0;
    end
    else
    begin
      alarm_output_n       <= state != MAWS_ALARM;
      thermal_state_output <= ctrl[CTRL_TH_ASSIGN] && thermal_open;
      caution_output       <= ctrl[CTRL_CA_ASSIGN] && |warn;
    end
  end

endmodule

// file: verification/mawsup_props.sv
// Assertion checker for the alarm supervisor pins.
// Assumes it is bound to mawsup_top and sees its ports only.
`timescale 1ns/1ps

module mawsup_props
  import mawsup_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Host and sense inputs
  input wire logic        forward_run_input,
  input wire logic        reverse_run_input,
  input wire logic        coast_input,
  input wire logic        fault_clear_input,
  input wire logic        thermal_open,
  input wire logic        panel_clear,
  input wire logic [15:0] shaft_rpm,
  // Outputs
  input wire logic        alarm_output_n,
  input wire logic        brake_on,
  input wire logic        drive_en,
  input wire logic [15:0] speed_cmd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ----
  // Clear edges
  // ----
  sequence s_edge;
    $rose(fault_clear_input) && !panel_clear && !alarm_output_n;
  endsequence
  sequence s_good_clear;
    s_edge ##0 !forward_run_input && !reverse_run_input
      && !thermal_open && !$past(thermal_open);
  endsequence
  sequence s_bad_clear;
    s_edge ##0 (forward_run_input || reverse_run_input);
  endsequence

  // ----
  // Properties
  // ----
  property p_overheat;
    thermal_open |-> ##2 !alarm_output_n;
  endproperty
  property p_alarm_drive;
    !alarm_output_n |-> !drive_en;
  endproperty
  // Limit is strict: 2100 itself must not brake
  property p_brake;
    1'b1 |=> brake_on == ($past(shaft_rpm) > BRAKE_RPM);
  endproperty
  property p_clear;
    s_good_clear |=> ##1 alarm_output_n;
  endproperty
  property p_blocked;
    s_bad_clear |=> !alarm_output_n [*2];
  endproperty
  property p_run_pair;
    forward_run_input == reverse_run_input |=> !drive_en;
  endproperty
  property p_coast;
    coast_input |=> !drive_en;
  endproperty
  property p_speed;
    drive_en |-> speed_cmd != 16'h0000;
  endproperty

  a_overheat: assert property (p_overheat)
    else $error("overheat did not raise alarm");
  a_alarm_drive: assert property (p_alarm_drive)
    else $error("drive left on during alarm");
  a_brake: assert property (p_brake)
    else $error("brake does not follow speed");
  a_clear: assert property (p_clear)
    else $error("clear edge did not clear alarm");
  a_blocked: assert property (p_blocked)
    else $error("clear accepted while running");
  a_run_pair: assert property (p_run_pair)
    else $error("drive with both or no run input");
  a_coast: assert property (p_coast)
    else $error("drive while coasting");
  a_speed: assert property (p_speed)
    else $error("drive with zero speed");
endmodule

// file: verification/mawsup_host.sv
// Host model: drives run, coast, clear and select pins.
// Assumes the bench calls its tasks; pins move just after rising edges.
`timescale 1ns/1ps

module mawsup_host
(
  // Clock
  input  wire logic ref_clk,
  // Discrete inputs of the supervisor
  output logic      forward_run_input,
  output logic      reverse_run_input,
  output logic      coast_input,
  output logic      fault_clear_input,
  output logic      speed_select_bit0,
  output logic      speed_select_bit1
);
  initial
  begin
    {forward_run_input, reverse_run_input, coast_input} = 3'b000;
    {fault_clear_input, speed_select_bit1, speed_select_bit0} = 3'b000;
  end

  // Pins {forward, reverse, coast, select1, select0}
  task automatic put(input logic [4:0] v);
    @(posedge ref_clk);
    {forward_run_input, reverse_run_input, coast_input,
     speed_select_bit1, speed_select_bit0} <= v;
  endtask

  // Clear pulse with run inputs untouched; misuse only when asked
  task automatic pulse;
    @(posedge ref_clk);
    fault_clear_input <= 1'b1;
    repeat (2) @(posedge ref_clk);
    fault_clear_input <= 1'b0;
  endtask

  // Proper clear: both run inputs off before the edge
  task automatic clear;
    put({2'b00, coast_input, speed_select_bit1, speed_select_bit0});
    @(posedge ref_clk);
    pulse;
  endtask
endmodule

// file: verification/motor_alarm_warning_supervisor_test.sv
// Self-checking bench for the alarm and warning supervisor.
// Assumes the host model drives run pins and APB reaches the registers.
`timescale 1ns/1ps

module motor_alarm_warning_supervisor_test;
  import mawsup_pkg::*;
  localparam int unsigned LIM = 20;
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        err_q, thermal_open, shaft_locked, panel_clear, panel_write;
  logic [15:0] shaft_rpm, ext_speed, panel_speed, speed_cmd;
  logic        alarm_output_n, thermal_state_output, caution_output;
  logic        brake_on, drive_en, drive_forward;
  wire logic   forward_run_input, reverse_run_input, coast_input;
  wire logic   fault_clear_input, speed_select_bit0, speed_select_bit1;
  int          err_count, total_checks;

  mawsup_top #(.LOCK_LIMIT(LIM)) dut_u (.ref_clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .forward_run_input, .reverse_run_input, .coast_input,
    .fault_clear_input, .speed_select_bit0, .speed_select_bit1,
    .thermal_open, .shaft_locked, .shaft_rpm, .ext_speed, .panel_clear,
    .panel_write, .panel_speed, .alarm_output_n, .thermal_state_output,
    .caution_output, .brake_on, .drive_en, .drive_forward, .speed_cmd);
  mawsup_host host_u (.ref_clk, .forward_run_input, .reverse_run_input,
    .coast_input, .fault_clear_input, .speed_select_bit0,
    .speed_select_bit1);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_q, e);
  endtask
  // Look at mid-cycle, clear of the edge's updates, then return on a
  // rising edge so the next stimulus lands on it
  task automatic see(input int n, input logic [31:0] e);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({10'h000, thermal_state_output, caution_output, brake_on,
         alarm_output_n, drive_en, drive_forward, speed_cmd}, e);
    @(posedge ref_clk);
  endtask

  initial
  begin
    #300000;
    err_count++;
    results;
  end

  // ----
  // Tests
  // ----
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
    {thermal_open, shaft_locked, panel_clear, panel_write} = 4'h0;
    {shaft_rpm, panel_speed, ext_speed} = {32'h0, 16'h01F4};
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(REG_SPEED_LIM, 32'hFFFF_0000);
    rd(8'h20, 32'h0000_0000);
    chk({31'h0, err_q}, 32'h0000_0001);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    host_u.put(5'b10000);
    see(4, 32'h0007_01F4);
    ext_speed <= 16'h0230;
    see(4, 32'h0007_0230);
    host_u.put(5'b10010);
    see(4, 32'h0005_0000);
    host_u.put(5'b10000);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    see(4, 32'h0005_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    apb(1'b1, REG_OPDATA, 32'h0000_012C);
    host_u.put(5'b10001);
    see(4, 32'h0007_012C);
    apb(1'b1, REG_SPEED_LIM, 32'h0100_0000);
    see(4, 32'h0007_0100);
    apb(1'b1, REG_OPDATA, 32'h0000_0000);
    apb(1'b1, REG_SPEED_LIM, 32'h0100_0050);
    see(4, 32'h0007_0050);
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    see(4, 32'h0006_0050);
    host_u.put(5'b11001);
    see(4, 32'h0004_0000);
    host_u.put(5'b00001);
    see(4, 32'h0005_0000);
    host_u.put(5'b10101);
    see(4, 32'h0004_0000);
    @(posedge ref_clk);
    shaft_rpm <= 16'h0835;
    see(3, 32'h000C_0000);
    shaft_rpm <= 16'h0834;
    see(3, 32'h0004_0000);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, REG_CTRL, (i == 0) ? 32'h0000_0004 : 32'h0000_0000);
      {panel_speed, panel_write} <= {16'h0309, 1'b1};
      @(posedge ref_clk);
      panel_write <= 1'b0;
      rd(REG_OPDATA, (i == 0) ? 32'h0000_0000 : 32'h0000_0309);
    end
    apb(1'b1, REG_CTRL, 32'h0000_0020);
    host_u.put(5'b10001);
    thermal_open <= 1'b1;
    see(4, 32'h0021_0000);
    rd(REG_STATUS, 32'h0000_0005);
    thermal_open <= 1'b0;
    host_u.pulse;
    see(4, 32'h0001_0000);
    host_u.clear;
    see(4, 32'h0004_0000);
    rd(REG_HIST_DATA, {24'h0, MAWS_AL_OVERHEAT});
    thermal_open <= 1'b1;
    see(3, 32'h0020_0000);
    {thermal_open, panel_clear} <= 2'b01;
    @(posedge ref_clk);
    panel_clear <= 1'b0;
    see(4, 32'h0004_0000);
    apb(1'b1, REG_HIST_SEL, 32'h0000_0001);
    apb(1'b1, REG_CMD, 32'h0000_0002);
    rd(REG_HIST_DATA, {24'h0, MAWS_AL_OVERHEAT});
    apb(1'b1, REG_CTRL, 32'h0000_0008);
    apb(1'b1, REG_CMD, 32'h0000_0002);
    rd(REG_HIST_DATA, 32'h0000_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0040);
    host_u.put(5'b10001);
    shaft_locked <= 1'b1;
    see(LIM + 5, 32'h0017_0100);
    rd(REG_WARN, 32'h0000_0305);
    shaft_locked <= 1'b0;
    see(4, 32'h0007_0100);
    apb(1'b1, REG_CTRL, 32'h0000_0010);
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    see(4, 32'h0005_0000);
    rd(REG_WARN, 32'h0000_06CE);
    thermal_open <= 1'b1;
    see(3, 32'h0001_0000);
    thermal_open <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    see(2, 32'h0005_0000);
    rd(REG_WARN, 32'h0000_0000);
    results;
  end
endmodule

bind mawsup_top mawsup_props chk_u (.ref_clk, .rst_b,
  .forward_run_input, .reverse_run_input, .coast_input,
  .fault_clear_input, .thermal_open, .panel_clear, .shaft_rpm,
  .alarm_output_n, .brake_on, .drive_en, .speed_cmd);
